/* File: src/spc_defs.vh */
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// register map
`define SPC_ADDR_CTRL        12'h000
`define SPC_ADDR_STATUS      12'h004

// control register fields
`define SPC_MODE_LSB         0
`define SPC_MODE_MSB         1
`define SPC_THR_LSB          2
`define SPC_THR_MSB          10
`define SPC_CNT_LSB          11
`define SPC_CNT_MSB          15

// reset values
`define SPC_MODE_RST         2'h0
`define SPC_THR_RST          9'h000
`define SPC_CNT_RST          5'h01

// policy codes
`define SPC_POL_DEMOTE_SLV   2'h0
`define SPC_POL_DEMOTE_SW    2'h1
`define SPC_POL_THRESHOLD    2'h2
`define SPC_POL_EXTERNAL     2'h3

// threshold special codes
`define SPC_THR_HARD_FAULT_LVL 8'hFF
`define SPC_THR_NMI          8'hFE

// round robin reload
`define SPC_CNT_ONE          5'h01

`endif

/* File: src/spc_arb_core.v */
`timescale 1ns/1ns
`include "spc_defs.vh"

// arbitration core: fairness counter and grant choice
module spc_arb_core
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // policy
  input  wire [1:0] policy,
  input  wire [4:0] init_count,
  input  wire [8:0] threshold,
  input  wire [9:0] exec_pri,
  input  wire       ext_slave_pri,
  // requests
  input  wire       sw_req,
  input  wire       slv_req,
  // grants
  output reg        sw_gnt_nxt,
  output reg        slv_gnt_nxt,
  output wire [4:0] count
);

  reg  [4:0] cnt_r;
  reg  [4:0] cnt_nxt;
  reg  [4:0] reload;
  reg        slv_favoured;
  wire       contention;
  wire       demoted_wins;

  // signed priority: codes 1FF/1FE map to -1/-2, plain codes map to their low byte 0..255
  function signed [9:0] thr_pri;
    input [8:0] code;
    begin
      if (code[7:0] == `SPC_THR_HARD_FAULT_LVL && code[8])
        thr_pri = -10'sd1; // RULE10
      else if (code[7:0] == `SPC_THR_NMI && code[8])
        thr_pri = -10'sd2; // RULE10
      else
        thr_pri = $signed({2'b00, code[7:0]}); // RULE9
    end
  endfunction

  assign contention   = sw_req & slv_req;
  // counter at zero: favoured side has used its wins, demoted side goes next
  assign demoted_wins = (cnt_r == 5'h00);
  assign count        = cnt_r;

  always @*
  begin
    reload       = init_count;
    slv_favoured = 1'b0;
    case (policy)
      `SPC_POL_DEMOTE_SLV: slv_favoured = 1'b0; // RULE1
      `SPC_POL_DEMOTE_SW:  slv_favoured = 1'b1; // RULE2
      `SPC_POL_THRESHOLD:
      begin
        slv_favoured = 1'b0;
        // smaller number is higher priority
        if ($signed(exec_pri) <= thr_pri(threshold)) // RULE11
          reload = init_count; // RULE3
        else
          reload = `SPC_CNT_ONE; // RULE4
      end
      `SPC_POL_EXTERNAL:
      begin
        // count is ignored: the external level decides alone
        slv_favoured = ext_slave_pri; // RULE5
        reload       = `SPC_CNT_ONE;
      end
      default: slv_favoured = 1'b0;
    endcase
  end

  always @*
  begin
    sw_gnt_nxt  = 1'b0;
    slv_gnt_nxt = 1'b0;
    cnt_nxt     = cnt_r;
    if (contention)
    begin
      if (policy == `SPC_POL_EXTERNAL)
      begin
        slv_gnt_nxt = slv_favoured; // RULE5
        sw_gnt_nxt  = ~slv_favoured;
      end
      else if (demoted_wins)
      begin
        // a programmed zero would hand every contention to one side; treated as one
        slv_gnt_nxt = ~slv_favoured; // RULE13
        sw_gnt_nxt  = slv_favoured;
        cnt_nxt     = (reload == 5'h00) ? `SPC_CNT_ONE : reload; // RULE13
      end
      else
      begin
        slv_gnt_nxt = slv_favoured; // RULE13
        sw_gnt_nxt  = ~slv_favoured;
        cnt_nxt     = cnt_r - 5'h01; // RULE13
      end
    end
    else
    begin
      sw_gnt_nxt  = sw_req;
      slv_gnt_nxt = slv_req;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_r <= `SPC_CNT_RST;
    else
      cnt_r <= cnt_nxt;
  end

endmodule

/* File: src/spc_priority_ctrl.v */
`timescale 1ns/1ns
`include "spc_defs.vh"

// Behaviour
// RULE1: control 00 demotes slave-port traffic below software; this is reset value.
// RULE2: control 01 demotes software accesses below slave-port traffic.
// RULE3: control 10, execution priority at or above threshold: counter loads initial count.
// RULE4: control 10, execution priority below threshold: counter loads one, round robin.
// RULE5: control 11 takes priority from external input, initial count unused.
// RULE6: five-bit read-write initial count at bits 15:11, reset to one.
// RULE7: software never writes initial count zero, it risks livelock.
// RULE8: round robin: software sets count one and control 00 or 01.
// RULE9: threshold at bits 10:2; top bit clear means priority is low byte.
// RULE10: threshold code FF means priority -1, FE means priority -2.
// RULE11: larger numeric priority means lower priority when comparing with threshold.
// RULE12: bits 31:16 of control read zero and ignore writes.
// RULE13: counter counts lost contentions; on expiry demoted side wins once, reload.
module spc_priority_ctrl
(
  // clock and reset
  input  wire        MCLK,
  input  wire        SYS_RST,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // processor side, same clock
  input  wire [9:0]  EXEC_PRIORITY,
  input  wire        SW_REQ,
  input  wire        SLAVE_REQ,
  // external priority pin
  input  wire        EXT_SLAVE_PRI,
  // grants
  output reg         SW_GNT,
  output reg         SLAVE_GNT
);

  reg  [1:0]  mode_r;
  reg  [8:0]  thr_r;
  reg  [4:0]  cnt_init_r;
  reg         pri_meta_r;
  reg         pri_sync_r;
  reg         slv_last_r;
  reg         sw_last_r;
  reg  [31:0] rdata_nxt;
  reg         err_nxt;
  wire        setup;
  wire        wr_ctrl;
  wire        sw_gnt_nxt;
  wire        slv_gnt_nxt;
  wire [4:0]  cnt_now;

  // zero-wait slave: answer in the setup cycle so the access phase is one cycle
  assign setup   = PSEL & ~PENABLE;
  assign wr_ctrl = PSEL & PENABLE & PWRITE & (PADDR == `SPC_ADDR_CTRL);

  // external pin is asynchronous to MCLK
  always @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pri_meta_r <= 1'b0;
      pri_sync_r <= 1'b0;
    end
    else
    begin
      pri_meta_r <= EXT_SLAVE_PRI;
      pri_sync_r <= pri_meta_r;
    end
  end

  always @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      mode_r     <= `SPC_MODE_RST; // RULE1
      thr_r      <= `SPC_THR_RST;
      cnt_init_r <= `SPC_CNT_RST; // RULE6
    end
    else if (wr_ctrl)
    begin
      // upper half is dropped on write
      mode_r     <= PWDATA[`SPC_MODE_MSB:`SPC_MODE_LSB];
      thr_r      <= PWDATA[`SPC_THR_MSB:`SPC_THR_LSB]; // RULE9
      cnt_init_r <= PWDATA[`SPC_CNT_MSB:`SPC_CNT_LSB]; // RULE6
    end
  end

  always @*
  begin
    rdata_nxt = 32'h00000000;
    err_nxt   = 1'b0;
    case (PADDR)
      `SPC_ADDR_CTRL:
        rdata_nxt = {16'h0000, cnt_init_r, thr_r, mode_r}; // RULE12
      `SPC_ADDR_STATUS:
        rdata_nxt = {24'h000000, sw_last_r, slv_last_r, 1'b0, cnt_now};
      default:
        err_nxt = 1'b1;
    endcase
  end

  always @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= setup;
      PSLVERR <= setup & err_nxt;
      PRDATA  <= (setup & ~PWRITE) ? rdata_nxt : 32'h00000000;
    end
  end

  spc_arb_core u_core
  (
    .clk           (MCLK),
    .rst           (SYS_RST),
    .policy        (mode_r),
    .init_count    (cnt_init_r),
    .threshold     (thr_r),
    .exec_pri      (EXEC_PRIORITY),
    .ext_slave_pri (pri_sync_r),
    .sw_req        (SW_REQ),
    .slv_req       (SLAVE_REQ),
    .sw_gnt_nxt    (sw_gnt_nxt),
    .slv_gnt_nxt   (slv_gnt_nxt),
    .count         (cnt_now)
  );

  // registered grants cost a cycle but keep outputs glitch free
  always @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      SW_GNT     <= 1'b0;
      SLAVE_GNT  <= 1'b0;
      sw_last_r  <= 1'b0;
      slv_last_r <= 1'b0;
    end
    else
    begin
      SW_GNT    <= sw_gnt_nxt;
      SLAVE_GNT <= slv_gnt_nxt;
      if (SW_REQ & SLAVE_REQ)
      begin
        sw_last_r  <= sw_gnt_nxt;
        slv_last_r <= slv_gnt_nxt;
      end
    end
  end

endmodule

/* File: verification/spc_ahb_partner.sv */
`timescale 1ns/1ns
// far-side bus master: a pending transfer is kept until it is granted
module spc_ahb_partner
(
  // clock and reset
  input  wire clk,
  input  wire rst,
  // demand and grant
  input  wire want,
  input  wire gnt,
  output reg  req
);
  always @(posedge clk or posedge rst)
    if (rst)
      req <= 1'b0;
    else
      req <= want | (req & ~gnt);
endmodule

/* File: verification/spc_priority_ctrl_checker.sv */
`timescale 1ns/1ns
module spc_chk
(
  // apb
  input wire        MCLK,
  input wire        SYS_RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  // arbitration
  input wire        SW_REQ,
  input wire        SLAVE_REQ,
  input wire        EXT_SLAVE_PRI,
  input wire        SW_GNT,
  input wire        SLAVE_GNT
);
  reg [1:0] mode_r;
  // shadow of the policy field, snooped from completed writes
  always @(posedge MCLK or posedge SYS_RST)
    if (SYS_RST)
      mode_r <= 2'h0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000)
      mode_r <= PWDATA[1:0];
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // pin held across the two-flop synchroniser, then contention
  sequence s_ext_held;
    EXT_SLAVE_PRI [*3] ##0 (mode_r == 2'h3 && SW_REQ && SLAVE_REQ);
  endsequence
  a_apb_ready: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
  a_unmapped_err: assert property (PSEL && !PENABLE && PADDR[11:3] != 9'h0 |=> PSLVERR)
    else $error("no slverr");
  a_rsv_zero: assert property (PREADY && !PWRITE && PADDR == 12'h000 |->
    PRDATA[31:16] == 16'h0) else $error("reserved bits set");
  a_grant_one: assert property (!(SW_GNT && SLAVE_GNT)) else $error("double grant");
  a_sw_alone: assert property (SW_REQ && !SLAVE_REQ |=> SW_GNT) else $error("sw lost");
  a_slv_alone: assert property (SLAVE_REQ && !SW_REQ |=> SLAVE_GNT) else $error("slave lost");
  a_contend_win: assert property (SW_REQ && SLAVE_REQ |=> SW_GNT || SLAVE_GNT)
    else $error("no winner");
  a_ext_ctrl: assert property (s_ext_held |=> SLAVE_GNT) else $error("pin ignored");
endmodule
bind spc_priority_ctrl spc_chk u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SW_REQ(SW_REQ), .SLAVE_REQ(SLAVE_REQ),
  .EXT_SLAVE_PRI(EXT_SLAVE_PRI), .SW_GNT(SW_GNT), .SLAVE_GNT(SLAVE_GNT));

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [1:0] c; logic [4:0] n; logic [9:0] p; logic [8:0] t; logic x;
    logic s; int d;} spc_row_t;
  spc_row_t    rows [10];
  logic        MCLK, SYS_RST, PSEL, PENABLE, PWRITE, SW_REQ, want, EXT_SLAVE_PRI, e;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, q;
  logic [9:0]  EXEC_PRIORITY;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, SW_GNT, SLAVE_GNT, SLAVE_REQ;
  int          errors, num_checks, dw, fw;

  spc_priority_ctrl u_spc_priority_ctrl (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EXEC_PRIORITY(EXEC_PRIORITY), .SW_REQ(SW_REQ),
    .SLAVE_REQ(SLAVE_REQ), .EXT_SLAVE_PRI(EXT_SLAVE_PRI), .SW_GNT(SW_GNT),
    .SLAVE_GNT(SLAVE_GNT));
  spc_ahb_partner u_spc_ahb_partner (.clk(MCLK), .rst(SYS_RST), .want(want),
    .gnt(SLAVE_GNT), .req(SLAVE_REQ));

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, x, g);
    end
  endtask

  // one apb transfer: request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1)
      @(posedge MCLK);
    q = PRDATA;
    e = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask

  task finish_test;
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  initial
  begin
    #400000;
    errors++;
    finish_test;
  end

  initial
  begin
    {SYS_RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 47'h0};
    {SW_REQ, want, EXT_SLAVE_PRI, EXEC_PRIORITY} = 13'h0;
    // policy, count (never zero), priority, threshold, pin, slave demoted, demoted wins of 8
    rows = '{'{0,3,0,0,0,1,2}, '{0,1,0,0,0,1,4}, '{1,3,0,0,0,0,2},
      '{2,3,5,5,0,1,2}, '{2,3,6,5,0,1,4}, '{2,3,4,7,0,1,2}, '{2,3,10'h3FF,9'h1FF,0,1,2},
      '{2,3,0,9'h1FE,0,1,4}, '{3,5,0,0,1,0,0}, '{3,3,0,0,0,1,0}};
    repeat (5) @(posedge MCLK);
    SYS_RST <= 1'b0;
    foreach (rows[i])
    begin
      apb(1'b1, 12'h000, {16'hABCD, rows[i].n, rows[i].t, rows[i].c});
      apb(1'b0, 12'h000, 32'h0);
      chk("control", {16'h0, rows[i].n, rows[i].t, rows[i].c}, q);
      {SW_REQ, want, EXT_SLAVE_PRI, EXEC_PRIORITY} <= {2'b11, rows[i].x, rows[i].p};
      // warm-up lets the counter expire once and reload under the new policy
      repeat (8) @(posedge MCLK);
      dw = 0;
      fw = 0;
      repeat (8)
      begin
        @(posedge MCLK);
        dw += ((rows[i].s ? SLAVE_GNT : SW_GNT) === 1'b1);
        fw += ((rows[i].s ? SW_GNT : SLAVE_GNT) === 1'b1);
      end
      chk("demoted wins", rows[i].d, dw);
      chk("favoured wins", 8 - rows[i].d, fw);
      {SW_REQ, want} <= 2'b00;
    end
    apb(1'b0, 12'h004, 32'h0);
    chk("last winner", 32'h4, {29'h0, q[7:5]});
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    SYS_RST <= 1'b1;
    @(posedge MCLK);
    SYS_RST <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("reset control", 32'h00000800, q);
    apb(1'b0, 12'h004, 32'h0);
    chk("reset status", 32'h00000001, q);
    finish_test;
  end
endmodule
